// ===== logic/tps_map.vh
`ifndef TPS_MAP_VH
`define TPS_MAP_VH
// Register addresses on the plain register port.
`define TPS_ADDR_TIMER 8'h01
`define TPS_ADDR_OPTION 8'h81
`define TPS_ADDR_INTCTL 8'h0b
`define TPS_ADDR_WDTCLR 8'h90
`define TPS_ADDR_STATUS 8'h91
// Option register fields.
`define TPS_OPT_ASSIGN 3
`define TPS_OPT_SRC 5
`define TPS_OPT_RATIO_HI 2
`define TPS_OPT_RATIO_LO 0
// Interrupt control fields.
`define TPS_INT_GLOBAL_EN 7
`define TPS_INT_OVF_EN 5
`define TPS_INT_OVF_FLAG 2
// Reset values.
`define TPS_OPTION_RST 8'hff
`define TPS_INTCTL_RST 8'h00
`define TPS_ZERO8 8'h00
`define TPS_MAX8 8'hff
`define TPS_ONE8 8'h01
// Phase counter codes.
`define TPS_PH_FIRST 2'h0
`define TPS_PH_SECOND 2'h1
`define TPS_PH_THIRD 2'h2
`define TPS_PH_FOURTH 2'h3
`define TPS_PH_ONE 2'h1
// Watchdog postscaler input width.
`define TPS_WDT_W 8
`define TPS_WDT_ONE 8'h01
`endif

// ===== logic/tps_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "tps_map.vh"
// Shared eight-bit prescaler with ratio tap select.
// It is modelled as a synchronous counter stepped by an enable, so the
// symmetrical ripple output becomes a tap bit that toggles evenly.
module tps_prescaler (
    input wire clock,
    input wire rst_n,
    input wire step,
    input wire clear,
    input wire [2:0] ratio,
    output reg tap
);
    // Counter bits; never reachable from software.
    reg [7:0] count_reg;

    // Clear has priority over a step in the same cycle.
    always @(posedge clock) begin
        if (!rst_n || clear) begin
            count_reg <= `TPS_ZERO8;
        end else if (step) begin
            count_reg <= count_reg + `TPS_ONE8;
        end
    end

    // Ratio n taps bit n, giving divide by two to the n plus one.
    always @* begin
        tap = count_reg[ratio];
    end
endmodule
`default_nettype wire

// ===== logic/tps_timer.v
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tps_map.vh"
// Notes on behaviour
// - Oscillator divided into four phase clocks.
// - No prescaler: count input bypasses prescaler.
// - Count source sampled on phases two, four.
// - Prescaler divides count input, symmetrical output.
// - Timer increments three to seven periods later.
// - One eight-bit prescaler, timer or watchdog.
// - Assignment and ratio from option bits three-zero.
// - Timer write clears prescaler when assigned.
// - Watchdog clear resets watchdog, and prescaler when assigned.
// - Prescaler count has no software access.
module tps_timer (
    input wire clock,
    input wire rst_n,
    input wire ext_count_clock_in,
    input wire wdt_tick,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    output reg [7:0] timer_count_register,
    output reg timer_overflow_flag,
    output reg wdt_timeout,
    output reg irq_out,
    output reg phase_clock_two,
    output reg phase_clock_four
);
    // Two-stage synchroniser for the asynchronous count pin.
    reg pin_s1_reg;
    reg pin_s2_reg;
    // Phase counter: one instruction cycle is four clocks.
    reg [1:0] phase_reg;
    // Option register; bit 3 assigns, bits 2:0 pick the ratio.
    reg [7:0] option_reg;
    // Interrupt control register with the overflow flag in it.
    reg [7:0] intctl_reg;
    // Previous pin level, for the prescaler step edge.
    reg pin_prev_reg;
    // Sampled counter source and its previous sample.
    reg samp_reg;
    reg samp_prev_reg;
    // Watchdog counter; its carry out is the timeout event.
    reg [7:0] wdt_reg;
    reg wdt_tap_prev_reg;
    // High while the prescaler serves the watchdog, not the timer.
    wire pre_to_wdog;
    wire edge_sel;
    wire pin_edge;
    wire pre_tap;
    wire src;
    wire pre_step;
    wire pre_clear;
    wire sample_now;
    wire count_evt;
    wire wdt_evt;
    wire tmr_wr;
    wire wdt_clr;

    // Decodes a write to one address.
    function wr_hit;
        input [7:0] addr;
        input [7:0] want;
        input we;
        begin
            wr_hit = we && (addr == want);
        end
    endfunction

    assign pre_to_wdog = option_reg[`TPS_OPT_ASSIGN];
    assign edge_sel = option_reg[`TPS_OPT_SRC];
    assign tmr_wr = wr_hit(reg_addr, `TPS_ADDR_TIMER, reg_write);
    assign wdt_clr = wr_hit(reg_addr, `TPS_ADDR_WDTCLR, reg_write);
    // The chosen pin edge steps the prescaler when timer owns it.
    assign pin_edge = edge_sel ? (pin_prev_reg && !pin_s2_reg)
                               : (!pin_prev_reg && pin_s2_reg);
    // One counter, stepped by either the pin or the watchdog tick.
    assign pre_step = pre_to_wdog ? wdt_tick : pin_edge;
    // Clear on timer write or watchdog clear, by current owner.
    assign pre_clear = pre_to_wdog ? wdt_clr : tmr_wr;
    // Bypass the prescaler when it belongs to the watchdog.
    assign src = pre_to_wdog ? (pin_s2_reg ^ edge_sel) : pre_tap;
    assign sample_now = (phase_reg == `TPS_PH_SECOND)
                     || (phase_reg == `TPS_PH_FOURTH);
    // A rising sample of the source counts once.
    assign count_evt = sample_now && src && !samp_prev_reg;
    // Watchdog steps on its own tick or on the postscaler tap.
    assign wdt_evt = pre_to_wdog ? (pre_tap && !wdt_tap_prev_reg)
                                 : wdt_tick;

    tps_prescaler u_pre (
        .clock(clock),
        .rst_n(rst_n),
        .step(pre_step),
        .clear(pre_clear),
        .ratio(option_reg[`TPS_OPT_RATIO_HI:`TPS_OPT_RATIO_LO]),
        .tap(pre_tap)
    );

    // Synchroniser; the first stage feeds only the second.
    always @(posedge clock) begin
        if (!rst_n) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg <= ext_count_clock_in;
            pin_s2_reg <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // Phase counter and registered phase strobes.
    always @(posedge clock) begin
        if (!rst_n) begin
            phase_reg <= `TPS_PH_FIRST;
            phase_clock_two <= 1'b0;
            phase_clock_four <= 1'b0;
        end else begin
            phase_reg <= phase_reg + `TPS_PH_ONE;
            // Strobes show the phase that the counter now enters.
            phase_clock_two <= (phase_reg == `TPS_PH_FIRST);
            phase_clock_four <= (phase_reg == `TPS_PH_THIRD);
        end
    end

    // Source sampling only on phases two and four.
    always @(posedge clock) begin
        if (!rst_n) begin
            // Reset high: with falling-edge select and an idle low pin the
            // source sits high, and a low reset value would count a
            // phantom edge right after reset.
            samp_prev_reg <= 1'b1;
        end else if (sample_now) begin
            samp_prev_reg <= src;
        end
    end

    // Timer register; software write wins over a count.
    always @(posedge clock) begin
        if (!rst_n) begin
            timer_count_register <= `TPS_ZERO8;
        end else if (tmr_wr) begin
            timer_count_register <= reg_wdata;
        end else if (count_evt) begin
            timer_count_register <= timer_count_register
                                    + `TPS_ONE8;
        end
    end

    // Option and interrupt control; rollover set beats a clear.
    always @(posedge clock) begin
        if (!rst_n) begin
            option_reg <= `TPS_OPTION_RST;
            intctl_reg <= `TPS_INTCTL_RST;
        end else begin
            if (wr_hit(reg_addr, `TPS_ADDR_OPTION, reg_write)) begin
                option_reg <= reg_wdata;
            end
            if (wr_hit(reg_addr, `TPS_ADDR_INTCTL, reg_write)) begin
                intctl_reg <= reg_wdata;
            end
            if (count_evt && !tmr_wr
                && timer_count_register == `TPS_MAX8) begin
                intctl_reg[`TPS_INT_OVF_FLAG] <= 1'b1;
            end
        end
    end

    // Watchdog counter, cleared together with the prescaler when it owns the prescaler.
    always @(posedge clock) begin
        if (!rst_n) begin
            wdt_reg <= `TPS_ZERO8;
            wdt_tap_prev_reg <= 1'b0;
            wdt_timeout <= 1'b0;
        end else begin
            wdt_tap_prev_reg <= pre_tap;
            wdt_timeout <= 1'b0;
            if (wdt_clr) begin
                wdt_reg <= `TPS_ZERO8;
            end else if (wdt_evt) begin
                wdt_reg <= wdt_reg + `TPS_WDT_ONE;
                wdt_timeout <= (wdt_reg == `TPS_MAX8);
            end
        end
    end

    // Registered outputs and read data; prescaler is never readable.
    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= `TPS_ZERO8;
            timer_overflow_flag <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            timer_overflow_flag <= intctl_reg[`TPS_INT_OVF_FLAG];
            irq_out <= intctl_reg[`TPS_INT_GLOBAL_EN]
                       && intctl_reg[`TPS_INT_OVF_EN]
                       && intctl_reg[`TPS_INT_OVF_FLAG];
            reg_rdata <= `TPS_ZERO8;
            if (reg_read) begin
                case (reg_addr)
                    `TPS_ADDR_TIMER: begin
                        reg_rdata <= timer_count_register;
                    end
                    `TPS_ADDR_OPTION: begin
                        reg_rdata <= option_reg;
                    end
                    `TPS_ADDR_INTCTL: begin
                        reg_rdata <= intctl_reg;
                    end
                    `TPS_ADDR_STATUS: begin
                        reg_rdata <= wdt_reg;
                    end
                    default: begin
                        reg_rdata <= `TPS_ZERO8;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/tps_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_map.vh"
// Port-level checks on the timer; all but the phase and watchdog pulse checks tie an output to its cause.
module tps_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] timer_count_register,
    input wire logic timer_overflow_flag,
    input wire logic wdt_timeout,
    input wire logic phase_clock_two,
    input wire logic phase_clock_four
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Three quiet cycles, then the next phase-two strobe.
    sequence s_gap;
        !phase_clock_two [*3] ##1 phase_clock_two;
    endsequence
    // The timer passes from all ones to zero without a software write.
    sequence s_wrap;
        timer_count_register == 8'hff ##1
            (timer_count_register == 8'h00 && !$past(reg_write));
    endsequence
    a_phase_period: assert property (
        phase_clock_two |=> s_gap) else $error("phase period wrong");
    a_phase_apart: assert property (
        !(phase_clock_two && phase_clock_four)) else $error("phases overlap");
    a_phase_order: assert property (
        phase_clock_two |-> ##2 phase_clock_four) else $error("phase order");
    a_count_by_one: assert property (
        $changed(timer_count_register) && !$past(reg_write) |->
        timer_count_register == $past(timer_count_register) + 8'h01)
        else $error("timer step is not one");
    a_write_loads: assert property (
        reg_write && reg_addr == `TPS_ADDR_TIMER |=>
        timer_count_register == $past(reg_wdata)) else $error("timer load");
    a_wrap_flag: assert property (
        s_wrap |-> ##[0:1] timer_overflow_flag) else $error("no overflow flag");
    a_read_timer: assert property (
        reg_read && reg_addr == `TPS_ADDR_TIMER |=>
        reg_rdata == $past(timer_count_register)) else $error("timer read");
    a_rdata_idle: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("stray rdata");
    a_wdt_pulse: assert property (
        wdt_timeout |=> !wdt_timeout) else $error("long watchdog pulse");
endmodule
bind tps_timer tps_props tps_props_inst (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_count_register(timer_count_register),
    .timer_overflow_flag(timer_overflow_flag), .wdt_timeout(wdt_timeout),
    .phase_clock_two(phase_clock_two), .phase_clock_four(phase_clock_four));
`default_nettype wire

// ===== dv/tps_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none
// External pulse source on the count pin; idles low when stopped.
module tps_pulse_src (
    input wire logic clock,
    input wire logic run,
    output logic pin
);
    logic [1:0] cnt_reg; // Cycles spent at the present level.
    // Each level lasts two periods, the least the bypass path can sample.
    always @(posedge clock) begin
        if (!run) begin
            pin <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (cnt_reg == 2'h1) begin
            pin <= ~pin;
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, src_run = 1'b0, wdt_tick = 1'b0;
    logic reg_write = 1'b0, reg_read = 1'b0, pin_q = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, old_val;
    wire [7:0] reg_rdata, timer_val;
    wire ext_pin, flag, wdt_to, irq, ph2, ph4;
    int fail_count = 0, comparisons = 0, rises = 0, base = 0, n;
    int wdt_pulses = 0;
    // Rows hold address, written value and value read back.
    logic [23:0] rows [4] = '{24'h01_5a5a, 24'h0b_a0a0, 24'h55_3300,
                              24'h81_0808};
    always #25 clock = ~clock;
    tps_timer tps_timer_inst (.clock(clock), .rst_n(rst_n),
        .ext_count_clock_in(ext_pin), .wdt_tick(wdt_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .timer_count_register(timer_val), .timer_overflow_flag(flag),
        .wdt_timeout(wdt_to), .irq_out(irq), .phase_clock_two(ph2),
        .phase_clock_four(ph4));
    tps_pulse_src tps_pulse_src_inst (.clock(clock), .run(src_run),
        .pin(ext_pin));
    // Counting rising edges of the pin gives the expected count.
    // Watchdog timeout pulses are counted beside them.
    always @(posedge clock) begin
        pin_q <= ext_pin;
        if (ext_pin && !pin_q) rises <= rises + 1;
        if (wdt_to) wdt_pulses <= wdt_pulses + 1;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Runs the source until k more rising edges, then lets the sync drain.
    task run_rises(input int k);
        src_run <= 1'b1;
        for (n = 0; rises - base < k; n++) begin
            if (n > 20000) begin
                fail_count++;
                summarize();
            end
            @(posedge clock);
            #1;
        end
        @(posedge clock) src_run <= 1'b0;
        repeat (12) @(posedge clock);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        // Bypass path: measure pin-to-timer delay, then count edges.
        wr(8'h01, 8'h00);
        base = rises;
        @(posedge clock) src_run <= 1'b1;
        for (n = 0; n < 20 && !ext_pin; n++) @(posedge clock) #1;
        old_val = timer_val;
        for (n = 0; n < 12 && timer_val === old_val; n++) @(posedge clock) #1;
        chk({7'h00, n >= 3 && n <= 7}, 8'h01);
        run_rises(12);
        rd(8'h01, 8'h0c);
        // Falling-edge select on the bypass path counts each fall.
        wr(8'h81, 8'h28);
        wr(8'h01, 8'h00);
        base = rises;
        run_rises(3);
        rd(8'h01, 8'h03);
        // Every ratio code, each run giving exactly two timer counts.
        for (int r = 0; r < 8; r++) begin
            wr(8'h81, 8'(r));
            wr(8'h01, 8'h00);
            base = rises;
            run_rises(4 << r);
            rd(8'h01, 8'h02);
        end
        wr(8'h81, 8'h08);
        wr(8'h0b, 8'ha0);
        wr(8'h01, 8'hff);
        base = rises;
        run_rises(1);
        rd(8'h01, 8'h00);
        rd(8'h0b, 8'ha4);
        chk({7'h00, irq}, 8'h01);
        chk({7'h00, flag}, 8'h01);
        // Ratio 0 postscaler: five ticks give three watchdog counts.
        repeat (5) begin
            @(posedge clock) wdt_tick <= 1'b1;
            @(posedge clock) wdt_tick <= 1'b0;
        end
        rd(8'h91, 8'h03);
        wr(8'h90, 8'h00);
        rd(8'h91, 8'h00);
        // A cleared postscaler steps its tap on the very next tick.
        @(posedge clock) wdt_tick <= 1'b1;
        @(posedge clock) wdt_tick <= 1'b0;
        rd(8'h91, 8'h01);
        // Timer owns the prescaler: each tick steps the watchdog directly.
        wr(8'h81, 8'h00);
        wr(8'h90, 8'h00);
        repeat (255) begin
            @(posedge clock) wdt_tick <= 1'b1;
            @(posedge clock) wdt_tick <= 1'b0;
        end
        repeat (2) @(posedge clock);
        chk(8'(wdt_pulses), 8'h00);
        @(posedge clock) wdt_tick <= 1'b1;
        @(posedge clock) wdt_tick <= 1'b0;
        repeat (2) @(posedge clock);
        chk(8'(wdt_pulses), 8'h01);
        @(posedge clock) rst_n <= 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h81, 8'hff);
        rd(8'h0b, 8'h00);
        rd(8'h01, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
